// ### common/cpps_pkg.sv
// Constants, register indices and types for the constant-pressure pump sequencer.
// Assumes one 250 MHz control clock and software access over APB.
package cpps_pkg;
   localparam int CLK_MHZ     = 250;
   localparam int TICK_MS     = 100;
   localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
   localparam int MIN_MS      = 60000;
   localparam int MIN_TICKS   = MIN_MS / TICK_MS;
   localparam int CW          = 17;
   localparam int NCFG        = 23;
   localparam int NEV         = 7;

   localparam logic [4:0] I_MODE    = 5'h00;
   localparam logic [4:0] I_TGT_SRC = 5'h01;
   localparam logic [4:0] I_TARGET  = 5'h02;
   localparam logic [4:0] I_FS      = 5'h03;
   localparam logic [4:0] I_SLEEP_F = 5'h04;
   localparam logic [4:0] I_SLEEP_D = 5'h05;
   localparam logic [4:0] I_WAKE_P  = 5'h06;
   localparam logic [4:0] I_WAKE_D  = 5'h07;
   localparam logic [4:0] I_BAND    = 5'h08;
   localparam logic [4:0] I_ADD_F   = 5'h09;
   localparam logic [4:0] I_DROP_F  = 5'h0A;
   localparam logic [4:0] I_ADD_D   = 5'h0B;
   localparam logic [4:0] I_DROP_D  = 5'h0C;
   localparam logic [4:0] I_CHG     = 5'h0D;
   localparam logic [4:0] I_ROT     = 5'h0E;
   localparam logic [4:0] I_MARGIN  = 5'h0F;
   localparam logic [4:0] I_SH_SEL  = 5'h10;
   localparam logic [4:0] I_SH_CUR  = 5'h11;
   localparam logic [4:0] I_SH_RTY  = 5'h12;
   localparam logic [4:0] I_SH_JDG  = 5'h13;
   localparam logic [4:0] I_DEV     = 5'h14;
   localparam logic [4:0] I_UPPER   = 5'h15;
   localparam logic [4:0] I_RATED   = 5'h16;
   localparam logic [4:0] I_STAT    = 5'h17;
   localparam logic [4:0] I_IRQ     = 5'h18;
   localparam logic [4:0] I_MASK    = 5'h19;

   localparam logic [CW-1:0] CFG_RST [NCFG] = '{
      17'h00000, 17'h00000, 17'h00014, 17'h00064, 17'h00BB8, 17'h00000,
      17'h00000, 17'h00000, 17'h00005, 17'h01388, 17'h003E8, 17'h00064,
      17'h00032, 17'h00005, 17'h00000, 17'h00000, 17'h00000, 17'h00050,
      17'h0003C, 17'h00014, 17'h00000, 17'h01388, 17'h00064};

   localparam logic [CW-1:0] MODE_MAX  = 17'h00002;
   localparam logic [CW-1:0] SRC_MAX   = 17'h00007;
   localparam logic [CW-1:0] FS_MAX    = 17'h003E8;
   localparam logic [CW-1:0] DLY_SW    = 17'h08CA0;
   localparam logic [CW-1:0] DLY_PUMP  = 17'h1869F;
   localparam logic [CW-1:0] BAND_MAX  = 17'h003E8;
   localparam logic [CW-1:0] CHG_MIN   = 17'h00001;
   localparam logic [CW-1:0] CHG_MAX   = 17'h00064;
   localparam logic [CW-1:0] PCT20_MAX = 17'h000C8;
   localparam logic [CW-1:0] CUR_MIN   = 17'h0000A;
   localparam logic [CW-1:0] CUR_MAX   = 17'h00096;
   localparam logic [CW-1:0] RTY_MAX   = 17'h00BB8;
   localparam logic [CW-1:0] JDG_MIN   = 17'h00014;
   localparam logic [CW-1:0] JDG_MAX   = 17'h00064;
   localparam logic [CW-1:0] ROT_MAX   = 17'h0FFFF;
   localparam logic [CW-1:0] ZERO      = 17'h00000;
   localparam logic [CW-1:0] DEN_TENTH = 17'h003E8;
   localparam logic [CW-1:0] DEN_WHOLE = 17'h00064;

   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_ONE = 2'h1;
   localparam logic [1:0] MODE_TWO = 2'h2;
   localparam logic [1:0] SH_NONE  = 2'h0;
   localparam logic [1:0] SH_SENS  = 2'h1;
   localparam logic [1:0] SH_LESS  = 2'h2;

   localparam int EV_SLEEP = 0;
   localparam int EV_WAKE  = 1;
   localparam int EV_ADD   = 2;
   localparam int EV_DROP  = 3;
   localparam int EV_ROT   = 4;
   localparam int EV_SH_ON = 5;
   localparam int EV_SH_OFF = 6;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_RUN   = 5'h02,
      ST_GAP   = 5'h04,
      ST_DUAL  = 5'h08,
      ST_SLEEP = 5'h10
   } cpps_state_t;
endpackage

// ### common/cpps_tmr_if.sv
// Handshake between the sequencer and one qualifying delay timer.
// Assumes qual, tick and limit are driven on the same clock as the timer.
`timescale 1ns/1ps
interface cpps_tmr_if;
   logic          qual;
   logic          tick;
   logic [16:0]   limit;
   logic          done;
   modport timer (input qual, input tick, input limit, output done);
   modport user  (output qual, output tick, output limit, input done);
endinterface

// ### rtl/cpps_delay_timer.sv
// Qualifying delay timer: done once qual has held for limit ticks.
// Assumes tick is a one-cycle pulse on pclk.
`timescale 1ns/1ps
module cpps_delay_timer
   import cpps_pkg::*;
(
   input wire logic   pclk,
   input wire logic   presetn,
   cpps_tmr_if.timer  t
);
   logic [CW-1:0] cnt;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt    <= '0;
         t.done <= 1'b0;
      end
      else if (!t.qual)
      begin
         cnt    <= '0;
         t.done <= 1'b0;
      end
      else if (cnt >= t.limit)
         t.done <= 1'b1;
      else if (t.tick)
         cnt <= cnt + 17'h00001;
   end
endmodule

// ### rtl/cpps_sequencer.sv
// Sleep, wake, pump staging, rotation and shortage sequencer with APB registers.
// Assumes process inputs on pclk; shortage terminals arrive asynchronously.
`timescale 1ns/1ps
module cpps_sequencer
   import cpps_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
)
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          run_enable,
   input  wire logic [15:0]   pressure_fb,
   input  wire logic [15:0]   pid_target_ext,
   input  wire logic [15:0]   out_freq,
   input  wire logic [15:0]   out_current,
   input  wire logic          di_shortage,
   input  wire logic          di_enough_water,
   output logic      [1:0]    pump_drive,
   output logic      [1:0]    pump_mains,
   output logic               pump_lead,
   output logic               sleep_state,
   output logic               speed_hold_zero,
   output logic               shortage_warn,
   output logic               irq
);
   logic [CW-1:0]   cfg [NCFG];
   cpps_state_t     state;
   cpps_state_t     next_state;
   logic            lead;
   logic            next_lead;
   logic            gap_add;
   logic            next_gap_add;
   logic            warn;
   logic            next_warn;
   logic [NEV-1:0]  ev;
   logic [NEV-1:0]  irq_stat;
   logic [NEV-1:0]  irq_mask;
   logic [NEV-1:0]  next_irq;
   logic [1:0]      di_meta;
   logic [1:0]      di_sync;
   logic [31:0]     tick_cnt;
   logic            tick;
   logic [9:0]      min_cnt;
   logic            min_tick;

   function automatic logic [CW-1:0] lim(input logic [CW-1:0] d,
                                         input logic [CW-1:0] lo,
                                         input logic [CW-1:0] hi);
      return (d < lo) ? lo : ((d > hi) ? hi : d);
   endfunction

   function automatic logic [CW-1:0] umin(input logic [CW-1:0] a,
                                          input logic [CW-1:0] b);
      return (a < b) ? a : b;
   endfunction

   // Percentage of a value; den picks tenths or whole percent
   function automatic logic [CW-1:0] pct_of(input logic [CW-1:0] v,
                                            input logic [CW-1:0] p,
                                            input logic [CW-1:0] den);
      logic [2*CW-1:0] prod;
      prod = v * p;
      prod = prod / {17'h00000, den};
      return prod[CW-1:0];
   endfunction

   function automatic logic [1:0] pump_vec(input logic l);
      return l ? 2'b10 : 2'b01;
   endfunction

   // Settings are clamped at write so downstream compares stay simple
   function automatic logic [CW-1:0] clamp_cfg(input logic [4:0]    idx,
                                               input logic [CW-1:0] d,
                                               input logic [CW-1:0] fs,
                                               input logic [CW-1:0] tgt);
      logic [CW-1:0] r;
      r = d;
      case (idx)
         I_MODE:    r = lim(d, ZERO, MODE_MAX);
         I_TGT_SRC: r = lim(d, ZERO, SRC_MAX);
         I_TARGET:  r = lim(d, ZERO, fs);
         I_FS:      r = lim(d, ZERO, FS_MAX);
         I_SLEEP_D: r = lim(d, ZERO, DLY_SW);
         I_WAKE_P:  r = lim(d, ZERO, tgt);
         I_WAKE_D:  r = lim(d, ZERO, DLY_SW);
         I_BAND:    r = lim(d, ZERO, BAND_MAX);
         I_ADD_D:   r = lim(d, ZERO, DLY_PUMP);
         I_DROP_D:  r = lim(d, ZERO, DLY_PUMP);
         I_CHG:     r = lim(d, CHG_MIN, CHG_MAX);
         I_ROT:     r = lim(d, ZERO, ROT_MAX);
         I_MARGIN:  r = lim(d, ZERO, PCT20_MAX);
         I_SH_SEL:  r = lim(d, ZERO, MODE_MAX);
         I_SH_CUR:  r = lim(d, CUR_MIN, CUR_MAX);
         I_SH_RTY:  r = lim(d, ZERO, RTY_MAX);
         I_SH_JDG:  r = lim(d, JDG_MIN, JDG_MAX);
         I_DEV:     r = lim(d, ZERO, PCT20_MAX);
         default:   r = d;
      endcase
      return r;
   endfunction

   // APB decode
   wire logic [4:0]  idx = paddr[6:2];
   wire logic        mapped = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0)
                              && (idx <= I_MASK);
   wire logic        is_cfg = idx < 5'(NCFG);
   wire logic        acc_first = psel & penable & ~pready;
   wire logic        fire = psel & penable & pready & mapped;
   wire logic        wr_fire = fire & pwrite;
   wire logic        rd_clr = fire & ~pwrite & (idx == I_IRQ);
   wire logic [31:0] status = {25'h0000000, warn, lead, state};
   wire logic [31:0] cfg_rd = {15'h0000, cfg[is_cfg ? idx : I_MODE]};
   wire logic [31:0] rd_val = is_cfg ? cfg_rd :
                              (idx == I_STAT) ? status :
                              (idx == I_IRQ) ? {25'h0000000, irq_stat} :
                              {25'h0000000, irq_mask};

   // Process values
   wire logic [1:0]    mode = cfg[I_MODE][1:0];
   wire logic [1:0]    sh_sel = cfg[I_SH_SEL][1:0];
   wire logic [CW-1:0] fs = cfg[I_FS];
   wire logic [CW-1:0] fb = {1'b0, pressure_fb};
   wire logic [CW-1:0] freq = {1'b0, out_freq};
   wire logic [CW-1:0] cur = {1'b0, out_current};
   wire logic [CW-1:0] tgt_raw = (cfg[I_TGT_SRC] == ZERO) ? cfg[I_TARGET]
                                 : {1'b0, pid_target_ext};
   wire logic [CW-1:0] target = umin(tgt_raw, fs);
   wire logic [CW-1:0] dev = pct_of(fs, cfg[I_DEV], DEN_TENTH);
   wire logic [CW-1:0] margin = (mode == MODE_ONE) ?
                                pct_of(fs, cfg[I_MARGIN], DEN_TENTH) : ZERO;
   wire logic [CW+1:0] fb_lift = {2'b00, fb} + {2'b00, dev} + {2'b00, margin};
   wire logic          in_range = fb_lift >= {2'b00, target};
   wire logic [CW-1:0] wake_lvl = umin(cfg[I_WAKE_P], target);
   wire logic [CW-1:0] add_band = pct_of(cfg[I_ADD_F], cfg[I_BAND], DEN_TENTH);
   wire logic [CW-1:0] drop_band = pct_of(cfg[I_DROP_F], cfg[I_BAND], DEN_TENTH);
   wire logic [CW:0]   add_reach = {1'b0, freq} + {1'b0, add_band};
   wire logic [CW:0]   drop_reach = {1'b0, cfg[I_DROP_F]} + {1'b0, drop_band};
   wire logic [CW-1:0] cur_lim = pct_of(cfg[I_RATED], cfg[I_SH_CUR], DEN_WHOLE);
   wire logic          pumping = (state == ST_RUN) || (state == ST_DUAL);

   cpps_tmr_if t_sleep ();
   cpps_tmr_if t_wake ();
   cpps_tmr_if t_add ();
   cpps_tmr_if t_drop ();
   cpps_tmr_if t_gap ();
   cpps_tmr_if t_rot ();
   cpps_tmr_if t_judge ();
   cpps_tmr_if t_retry ();

   // Sleep only with a nonzero delay, from single-drive running
   assign t_sleep.qual = (state == ST_RUN) && (cfg[I_SLEEP_D] != ZERO)
                         && in_range && (freq < cfg[I_SLEEP_F]);
   assign t_sleep.tick = tick;
   assign t_sleep.limit = cfg[I_SLEEP_D];
   assign t_wake.qual = (state == ST_SLEEP) && (fb < wake_lvl);
   assign t_wake.tick = tick;
   assign t_wake.limit = cfg[I_WAKE_D];
   assign t_add.qual = (state == ST_RUN) && (mode == MODE_TWO)
                       && (add_reach >= {1'b0, cfg[I_ADD_F]}) && (fb < target);
   assign t_add.tick = tick;
   assign t_add.limit = cfg[I_ADD_D];
   assign t_drop.qual = (state == ST_DUAL)
                        && ({1'b0, freq} <= drop_reach) && (fb > target);
   assign t_drop.tick = tick;
   assign t_drop.limit = cfg[I_DROP_D];
   assign t_gap.qual = (state == ST_GAP);
   assign t_gap.tick = tick;
   assign t_gap.limit = cfg[I_CHG];
   assign t_rot.qual = (state == ST_RUN) && (mode == MODE_TWO)
                       && (cfg[I_ROT] != ZERO);
   assign t_rot.tick = min_tick;
   assign t_rot.limit = cfg[I_ROT];
   assign t_judge.qual = (sh_sel == SH_LESS) && !warn && pumping
                         && (freq >= cfg[I_UPPER]) && (cur < cur_lim);
   assign t_judge.tick = tick;
   assign t_judge.limit = cfg[I_SH_JDG];
   assign t_retry.qual = (sh_sel == SH_LESS) && warn;
   assign t_retry.tick = min_tick;
   assign t_retry.limit = cfg[I_SH_RTY];

   cpps_delay_timer u_sleep (.pclk(pclk), .presetn(presetn), .t(t_sleep));
   cpps_delay_timer u_wake  (.pclk(pclk), .presetn(presetn), .t(t_wake));
   cpps_delay_timer u_add   (.pclk(pclk), .presetn(presetn), .t(t_add));
   cpps_delay_timer u_drop  (.pclk(pclk), .presetn(presetn), .t(t_drop));
   cpps_delay_timer u_gap   (.pclk(pclk), .presetn(presetn), .t(t_gap));
   cpps_delay_timer u_rot   (.pclk(pclk), .presetn(presetn), .t(t_rot));
   cpps_delay_timer u_judge (.pclk(pclk), .presetn(presetn), .t(t_judge));
   cpps_delay_timer u_retry (.pclk(pclk), .presetn(presetn), .t(t_retry));

   always_comb
   begin
      next_state = state;
      next_lead = lead;
      next_gap_add = gap_add;
      next_warn = warn;
      ev = '0;
      unique case (sh_sel)
         SH_SENS:
         begin
            if (di_sync[0])
               next_warn = 1'b1;
            else if (di_sync[1])
               next_warn = 1'b0;
         end
         SH_LESS:
         begin
            if (!warn && t_judge.done)
               next_warn = 1'b1;
            else if (warn && t_retry.done)
               next_warn = 1'b0;
         end
         default:
            next_warn = 1'b0;
      endcase
      ev[EV_SH_ON] = next_warn & ~warn;
      ev[EV_SH_OFF] = warn & ~next_warn;
      // Shortage or a disabled mode parks every pump
      if ((mode == MODE_OFF) || !run_enable || warn)
         next_state = ST_IDLE;
      else
      begin
         unique case (state)
            ST_IDLE:
               next_state = ST_RUN;
            ST_RUN:
            begin
               if (t_sleep.done)
               begin
                  next_state = ST_SLEEP;
                  ev[EV_SLEEP] = 1'b1;
               end
               else if (t_add.done)
               begin
                  next_state = ST_GAP;
                  next_gap_add = 1'b1;
               end
               else if (t_rot.done)
               begin
                  next_state = ST_GAP;
                  next_gap_add = 1'b0;
                  next_lead = ~lead;
                  ev[EV_ROT] = 1'b1;
               end
            end
            ST_GAP:
            begin
               if (t_gap.done)
               begin
                  next_state = gap_add ? ST_DUAL : ST_RUN;
                  ev[EV_ADD] = gap_add;
               end
            end
            ST_DUAL:
            begin
               if (t_drop.done)
               begin
                  next_state = ST_RUN;
                  next_lead = ~lead;
                  ev[EV_DROP] = 1'b1;
               end
            end
            ST_SLEEP:
            begin
               if (t_wake.done)
               begin
                  next_state = ST_RUN;
                  ev[EV_WAKE] = 1'b1;
               end
            end
         endcase
      end
      if (mode != MODE_TWO)
         next_lead = 1'b0;
   end

   // Drive-fed pump stays off through the gap so contactors never overlap
   wire logic [1:0] next_drive = (next_state == ST_RUN) ? pump_vec(next_lead) :
                                 (next_state == ST_DUAL) ? pump_vec(~next_lead) :
                                 2'b00;
   wire logic [1:0] next_mains = (next_state == ST_DUAL) ? pump_vec(next_lead)
                                 : 2'b00;
   // Set wins over the read clear; only bits already returned are cleared
   assign next_irq = (irq_stat & ~(rd_clr ? prdata[NEV-1:0] : '0)) | ev;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         di_meta <= 2'b00;
         di_sync <= 2'b00;
      end
      else
      begin
         di_meta <= {di_enough_water, di_shortage};
         di_sync <= di_meta;
      end
   end

   // 0.1 s time base and minute base for the long delays
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_cnt <= '0;
         tick <= 1'b0;
         min_cnt <= '0;
         min_tick <= 1'b0;
      end
      else
      begin
         tick <= (tick_cnt == 32'(TICK_CYC - 1));
         tick_cnt <= (tick_cnt == 32'(TICK_CYC - 1)) ? '0 : tick_cnt + 32'h00000001;
         min_tick <= tick && (min_cnt == 10'(MIN_TICKS - 1));
         if (tick)
            min_cnt <= (min_cnt == 10'(MIN_TICKS - 1)) ? '0 : min_cnt + 10'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         pready <= acc_first;
         if (acc_first)
         begin
            pslverr <= ~mapped;
            prdata <= (mapped && !pwrite) ? rd_val : 32'h00000000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < NCFG; i++)
            cfg[i] <= CFG_RST[i];
         irq_mask <= '0;
      end
      else if (wr_fire)
      begin
         if (is_cfg)
            cfg[idx] <= clamp_cfg(idx, pwdata[CW-1:0], fs, cfg[I_TARGET]);
         else if (idx == I_MASK)
            irq_mask <= pwdata[NEV-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ST_IDLE;
         lead <= 1'b0;
         gap_add <= 1'b0;
         warn <= 1'b0;
         irq_stat <= '0;
         irq <= 1'b0;
         pump_drive <= 2'b00;
         pump_mains <= 2'b00;
         pump_lead <= 1'b0;
         sleep_state <= 1'b0;
         speed_hold_zero <= 1'b1;
         shortage_warn <= 1'b0;
      end
      else
      begin
         state <= next_state;
         lead <= next_lead;
         gap_add <= next_gap_add;
         warn <= next_warn;
         irq_stat <= next_irq;
         irq <= |(next_irq & irq_mask);
         pump_drive <= next_drive;
         pump_mains <= next_mains;
         pump_lead <= next_lead;
         sleep_state <= (next_state == ST_SLEEP);
         speed_hold_zero <= (next_state != ST_RUN) && (next_state != ST_DUAL);
         shortage_warn <= next_warn;
      end
   end
endmodule

// ### tb/cpps_plant.sv
// Contactor and level-sensor model at the pump outputs.
// Assumes dry is driven by the bench on pclk.
`timescale 1ns/1ps
module cpps_plant
(
   input  wire logic         pclk,
   input  wire logic         dry,
   input  wire logic [1:0]   pump_drive,
   input  wire logic [1:0]   pump_mains,
   output logic              di_shortage,
   output logic              di_enough_water,
   output int                clash
);
   // Two level contacts, both driven from the one dry input
   assign di_shortage     = dry;
   assign di_enough_water = !dry;
   initial clash = 0;
   // Closing both feeds would short drive to mains
   always @(posedge pclk)
      if ((pump_drive & pump_mains) != 2'h0)
         clash <= clash + 1;
endmodule

// ### tb/cpps_sequencer_props.sv
// Concurrent checks on the pump sequencer top ports.
// Assumes the single pclk domain and async active-low presetn.
`timescale 1ns/1ps
module cpps_sequencer_props
(
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire logic [1:0]    pump_drive,
   input wire logic [1:0]    pump_mains,
   input wire logic          sleep_state,
   input wire logic          speed_hold_zero,
   input wire logic          shortage_warn
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   one_wait_a: assert property ($rose(penable) && psel |=> pready)
      else $error("pready late");
   err_read_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   coil_lock_a: assert property ((pump_drive & pump_mains) == 2'h0)
      else $error("pump on both feeds");
   feed_gap_a: assert property ($rose(|pump_mains) |-> $past(pump_drive, 2) == 2'h0)
      else $error("no gap before mains");
   sleep_hold_a: assert property (sleep_state |-> speed_hold_zero)
      else $error("demand while asleep");
   sleep_entry_a: assert property ($rose(sleep_state) |-> !$past(speed_hold_zero))
      else $error("sleep not from run");
   run_pump_a: assert property (!speed_hold_zero |-> pump_drive != 2'h0)
      else $error("running with no pump");
   dry_stop_a: assert property (shortage_warn [*3] |-> (pump_drive | pump_mains) == 2'h0)
      else $error("pumps on in shortage");
endmodule

bind cpps_sequencer cpps_sequencer_props i_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .prdata, .pready, .pslverr, .pump_drive, .pump_mains, .sleep_state, .speed_hold_zero,
   .shortage_warn);

// ### tb/tb_constant_pressure_pump_sequencer.sv
// Self-checking bench for the pump sequencer over APB.
// Assumes TICK_CYC of 4, so one 0.1 s step is 4 clocks.
`timescale 1ns/1ps
module tb_constant_pressure_pump_sequencer
   import cpps_pkg::*;
();
   logic        pclk, presetn, psel, penable, pwrite, run_enable, dry, re;
   logic        pready, pslverr, pump_lead, sleep_state, speed_hold_zero, shortage_warn, irq;
   logic        di_shortage, di_enough_water;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rq;
   logic [15:0] pressure_fb, out_freq, pid_target_ext, out_current;
   logic [1:0]  pump_drive, pump_mains;
   int          num_errors, n_tests, clash;
   cpps_sequencer #(.TICK_CYC(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .run_enable, .pressure_fb,
      .pid_target_ext, .out_freq, .out_current, .di_shortage,
      .di_enough_water, .pump_drive, .pump_mains, .pump_lead, .sleep_state,
      .speed_hold_zero, .shortage_warn, .irq);
   cpps_plant i_plant (.pclk, .dry, .pump_drive, .pump_mains, .di_shortage,
      .di_enough_water, .clash);
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic apb(input logic w, input logic [4:0] i, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {5'h00, i, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e)
      begin
         num_errors++;
         $display("ERROR %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic close_out;
      $display("Checks %0d, errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Two one-minute waits dominate; the run is near 5000 clocks
   initial
   begin
      cyc(12000);
      num_errors++;
      close_out();
   end
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, run_enable, dry} = 5'h00;
      {paddr, pwdata} = 44'h0;
      {pressure_fb, out_freq} = {16'h0014, 16'h0FA0};
      {pid_target_ext, out_current} = {16'h0064, 16'h0000};
      cyc(3);
      presetn <= 1'b1;
      for (int i = 0; i < NCFG; i++)
      begin
         apb(1'b0, 5'(i), 32'h0);
         chk(rq, {15'h0, CFG_RST[i]});
      end
      apb(1'b0, 5'h1F, 32'h0);
      chk({rq[30:0], re}, 32'h1);
      apb(1'b1, I_FS, 32'h7D0);
      apb(1'b0, I_FS, 32'h0);
      chk(rq, 32'h3E8);
      apb(1'b1, I_MODE, 32'h7);
      apb(1'b0, I_MODE, 32'h0);
      chk(rq, 32'h2);
      apb(1'b1, I_SLEEP_D, 32'h3);
      apb(1'b1, I_WAKE_P, 32'hA);
      apb(1'b1, I_WAKE_D, 32'h2);
      apb(1'b1, I_MODE, 32'h1);
      run_enable <= 1'b1;
      cyc(4);
      chk(pump_drive, 2'h1);
      // Break the sleep condition once to see the timer restart
      out_freq <= 16'h07D0;
      cyc(6);
      out_freq <= 16'h0FA0;
      cyc(1);
      out_freq <= 16'h07D0;
      cyc(6);
      chk(sleep_state, 1'b0);
      cyc(14);
      chk({sleep_state, speed_hold_zero, irq}, 3'h6);
      apb(1'b1, I_MASK, 32'h7F);
      cyc(2);
      chk(irq, 1'b1);
      apb(1'b0, I_IRQ, 32'h0);
      chk(rq, 32'h1);
      cyc(2);
      chk(irq, 1'b0);
      pressure_fb <= 16'h0005;
      cyc(16);
      chk({sleep_state, pump_drive}, 3'h1);
      apb(1'b1, I_ADD_D, 32'h2);
      out_freq <= 16'h137E;
      apb(1'b1, I_MODE, 32'h2);
      cyc(12);
      chk({pump_drive, pump_mains}, 4'h0);
      cyc(30);
      chk({pump_drive, pump_mains}, 4'h9);
      apb(1'b1, I_SLEEP_D, 32'h0);
      apb(1'b1, I_DROP_D, 32'h1);
      {pressure_fb, out_freq} <= {16'h001E, 16'h03E8};
      cyc(30);
      chk({sleep_state, pump_lead, pump_drive, pump_mains}, 6'h18);
      apb(1'b1, I_SH_SEL, 32'h1);
      dry <= 1'b1;
      cyc(8);
      chk({shortage_warn, pump_drive}, 3'h4);
      dry <= 1'b0;
      cyc(8);
      chk(shortage_warn, 1'b0);
      apb(1'b0, I_IRQ, 32'h0);
      chk(rq, 32'h6E);
      chk(clash, 32'h0);
      // Rotation waits for the free-running minute base, about 2400 clocks
      apb(1'b1, I_ROT, 32'h1);
      cyc(2000);
      chk(pump_lead, 1'b1);
      cyc(200);
      chk({pump_lead, pump_drive, pump_mains}, 5'h04);
      apb(1'b1, I_ROT, 32'h0);
      apb(1'b1, I_SH_SEL, 32'h2);
      apb(1'b1, I_SH_RTY, 32'h1);
      out_freq <= 16'h1388;
      cyc(100);
      chk({shortage_warn, pump_drive}, 3'h4);
      // Current above the limit keeps the rejudge from warning again
      out_current <= 16'h0064;
      cyc(2100);
      chk(shortage_warn, 1'b1);
      cyc(200);
      chk({shortage_warn, pump_drive}, 3'h1);
      // External target of 1.00MPa puts feedback below target
      apb(1'b1, I_TGT_SRC, 32'h1);
      cyc(60);
      chk({pump_drive, pump_mains}, 4'h9);
      chk(clash, 32'h0);
      close_out();
   end
endmodule
